//--- scad_pkg.sv
// shared constants for the strap configuration loader and address decode
package scad_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;     // clk_sys period at 20 MHz
  localparam int SETTLE_NS     = 10000;  // pin settle time before sampling
  // least time, so round up to whole cycles
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // pin connection kinds reported by the analog detector
  localparam logic [1:0] KIND_LOW  = 2'h0;
  localparam logic [1:0] KIND_OPEN = 2'h1;
  localparam logic [1:0] KIND_HIGH = 2'h2;
  localparam logic [1:0] KIND_RES  = 2'h3;
  localparam logic [4:0] RES_MAX   = 5'h1e;  // 31 resistor selections, 0..30

  // selection code: three straps then one code per resistor step
  localparam logic [5:0] SEL_LOW   = 6'h00;
  localparam logic [5:0] SEL_OPEN  = 6'h01;
  localparam logic [5:0] SEL_HIGH  = 6'h02;
  localparam logic [5:0] SEL_RES0  = 6'h03;

  // ==========================================================
  // pin slots
  localparam int NUM_PINS = 5;
  localparam int PIN_ADDR = 0;
  localparam int PIN_V0   = 1;
  localparam int PIN_V1   = 2;
  localparam int PIN_FREQ = 3;
  localparam int PIN_LOCK = 4;

  // ==========================================================
  // bus address decode
  localparam logic [6:0] ADDR_LOW  = 7'h26;
  localparam logic [6:0] ADDR_OPEN = 7'h28;
  localparam logic [6:0] ADDR_HIGH = 7'h28;  // no strap-high entry exists
  localparam logic [6:0] ADDR_RES0 = 7'h19;  // first resistor step

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_V0     = 8'h08;
  localparam logic [7:0] REG_V1     = 8'h0c;
  localparam logic [7:0] REG_FREQ   = 8'h10;
  localparam logic [7:0] REG_LOCK   = 8'h14;
  localparam logic [7:0] REG_STORE  = 8'h18;

  // status fields
  localparam int ST_DONE   = 0;
  localparam int ST_STORED = 1;
  localparam int ST_PG     = 2;
  localparam int ST_BAD    = 3;  // five bits, one per pin
  // address register fields
  localparam int AD_SECOND = 8;
  // store control fields
  localparam int SC_SAVE   = 0;
  localparam int SC_LOAD   = 1;

  localparam logic [5:0] STORE_TAG   = 6'h2a;  // marks a valid saved image
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : scad_pkg

//--- scad_pin_sampler.sv
// one multimode pin: synchroniser and one-shot latch of its selection
`timescale 1ns/10ps
`default_nettype none

module scad_pin_sampler
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // detector reading
  input  wire logic [1:0] pin_kind,
  input  wire logic [4:0] pin_res,
  // control
  input  wire logic       sample,
  // result
  output logic      [5:0] sel,
  output logic            bad
);

  // ==========================================================
  // state
  logic [6:0] sync1;       // first stage, read only by sync2
  logic [6:0] sync2;       // second stage, safe to decode
  logic [5:0] next_sel;
  logic       next_bad;

  // ==========================================================
  // classify the synchronised reading
  always_comb
  begin
    next_sel = sel;
    next_bad = bad;
    if (sample)
    begin
      next_bad = 1'b0;
      unique case (sync2[6:5])
        scad_pkg::KIND_LOW:  next_sel = scad_pkg::SEL_LOW;
        scad_pkg::KIND_OPEN: next_sel = scad_pkg::SEL_OPEN;
        scad_pkg::KIND_HIGH: next_sel = scad_pkg::SEL_HIGH;
        scad_pkg::KIND_RES:
        begin
          // an out-of-range step cannot be trusted; fall back to open
          if (sync2[4:0] > scad_pkg::RES_MAX)
          begin
            next_sel = scad_pkg::SEL_OPEN;
            next_bad = 1'b1;
          end
          else
          begin
            next_sel = scad_pkg::SEL_RES0 + {1'b0, sync2[4:0]};
          end
        end
      endcase
    end
  end

  // ==========================================================
  // registers; the latch only moves on the single sample pulse
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sel   <= scad_pkg::SEL_OPEN;
      bad   <= 1'b0;
    end
    else
    begin
      sync1 <= {pin_kind, pin_res};
      sync2 <= sync1;
      sel   <= next_sel;
      bad   <= next_bad;
    end
  end

endmodule : scad_pin_sampler

`default_nettype wire

//--- scad_store.sv
// retained store for the user configuration; deliberately never reset
`timescale 1ns/10ps
`default_nettype none

module scad_store
(
  // clock
  input  wire logic       clk_sys,
  // save port
  input  wire logic       save,
  input  wire logic [5:0] save_freq,
  input  wire logic [5:0] save_lock,
  // read port
  output logic            holds_image,
  output logic      [5:0] load_freq,
  output logic      [5:0] load_lock
);

  // ==========================================================
  // words: tag, frequency, lockout; no reset so contents outlive rst_n
  logic [5:0] mem [0:2];

  // save all words together so the tag never marks a half image
  always_ff @(posedge clk_sys)
  begin
    if (save)
    begin
      mem[0] <= scad_pkg::STORE_TAG;
      mem[1] <= save_freq;
      mem[2] <= save_lock;
    end
  end

  // read side
  assign holds_image = (mem[0] == scad_pkg::STORE_TAG);
  assign load_freq   = mem[1];
  assign load_lock   = mem[2];

endmodule : scad_store

`default_nettype wire

//--- scad_top.sv
// strap configuration loader with address decode and AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

module scad_top
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // detector readings, one pair per multimode pin
  input  wire logic [1:0]  address_select_pin_kind,
  input  wire logic [4:0]  address_select_pin_res,
  input  wire logic [1:0]  channel0_voltage_select_pin_kind,
  input  wire logic [4:0]  channel0_voltage_select_pin_res,
  input  wire logic [1:0]  channel1_voltage_select_pin_kind,
  input  wire logic [4:0]  channel1_voltage_select_pin_res,
  input  wire logic [1:0]  frequency_select_pin_kind,
  input  wire logic [4:0]  frequency_select_pin_res,
  input  wire logic [1:0]  input_lockout_select_pin_kind,
  input  wire logic [4:0]  input_lockout_select_pin_res,
  // regulation status from the power stage
  input  wire logic        outputs_in_regulation,
  // decoded configuration
  output logic      [6:0]  device_address,
  output logic      [6:0]  second_address,
  output logic      [5:0]  channel0_voltage_sel,
  output logic      [5:0]  channel1_voltage_sel,
  output logic      [5:0]  frequency_sel,
  output logic      [5:0]  input_lockout_sel,
  output logic             config_done,
  output logic             power_good,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);

  // ==========================================================
  // power-up sequence
  typedef enum logic [1:0] {SETTLE, SAMPLE, APPLY, RUN} scad_phase_e;

  scad_phase_e phase;        // where the loader stands
  scad_phase_e next_phase;
  logic [7:0]  settle_cnt;   // cycles spent settling
  logic [7:0]  next_settle_cnt;

  localparam logic [7:0] SETTLE_LAST = 8'(scad_pkg::SETTLE_CYC - 1);

  // pin readings gathered for the sampler loop
  logic [1:0] kind [scad_pkg::NUM_PINS];
  logic [4:0] res  [scad_pkg::NUM_PINS];
  logic [5:0] sel  [scad_pkg::NUM_PINS];
  logic [scad_pkg::NUM_PINS-1:0] bad;  // out-of-range resistor per pin

  assign kind[scad_pkg::PIN_ADDR] = address_select_pin_kind;
  assign res[scad_pkg::PIN_ADDR]  = address_select_pin_res;
  assign kind[scad_pkg::PIN_V0]   = channel0_voltage_select_pin_kind;
  assign res[scad_pkg::PIN_V0]    = channel0_voltage_select_pin_res;
  assign kind[scad_pkg::PIN_V1]   = channel1_voltage_select_pin_kind;
  assign res[scad_pkg::PIN_V1]    = channel1_voltage_select_pin_res;
  assign kind[scad_pkg::PIN_FREQ] = frequency_select_pin_kind;
  assign res[scad_pkg::PIN_FREQ]  = frequency_select_pin_res;
  assign kind[scad_pkg::PIN_LOCK] = input_lockout_select_pin_kind;
  assign res[scad_pkg::PIN_LOCK]  = input_lockout_select_pin_res;

  // step through settle, one sample pulse, one apply, then run forever
  always_comb
  begin
    next_phase      = phase;
    next_settle_cnt = settle_cnt;
    unique case (phase)
      SETTLE:
      begin
        // let detector readings settle before the single sample
        if (settle_cnt == SETTLE_LAST)
          next_phase = SAMPLE;
        else
          next_settle_cnt = settle_cnt + 8'h01;
      end
      SAMPLE:  next_phase = APPLY;
      APPLY:   next_phase = RUN;
      RUN:     next_phase = RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase      <= SETTLE;
      settle_cnt <= 8'h00;
    end
    else
    begin
      phase      <= next_phase;
      settle_cnt <= next_settle_cnt;
    end
  end

  // ==========================================================
  // one sampler per multimode pin
  genvar gi;
  generate
    for (gi = 0; gi < scad_pkg::NUM_PINS; gi++)
    begin : g_pin
      scad_pin_sampler u_pin
      (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pin_kind (kind[gi]),
        .pin_res  (res[gi]),
        .sample   (phase == SAMPLE),
        .sel      (sel[gi]),
        .bad      (bad[gi])
      );
    end
  endgenerate

  // address from the selection code of the address pin
  function automatic logic [6:0] scad_addr(input logic [5:0] s);
    logic [6:0] a;
    a = scad_pkg::ADDR_OPEN;
    if (s == scad_pkg::SEL_LOW)
      a = scad_pkg::ADDR_LOW;
    else if (s == scad_pkg::SEL_HIGH)
      a = scad_pkg::ADDR_HIGH;
    else if (s >= scad_pkg::SEL_RES0)
      a = scad_pkg::ADDR_RES0 + 7'(s - scad_pkg::SEL_RES0);
    return a;
  endfunction : scad_addr

  // ==========================================================
  // retained store
  logic       store_save;   // one-cycle save request
  logic       store_full;   // store holds a tagged image
  logic [5:0] store_freq;
  logic [5:0] store_lock;

  scad_store u_store
  (
    .clk_sys     (clk_sys),
    .save        (store_save),
    .save_freq   (frequency_sel),
    .save_lock   (input_lockout_sel),
    .holds_image (store_full),
    .load_freq   (store_freq),
    .load_lock   (store_lock)
  );

  // ==========================================================
  // bus slave state
  logic        aw_full, next_aw_full;   // write address held
  logic        w_full, next_w_full;     // write data held
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        do_write;                // both halves held, response free
  logic        wr_byte;                 // low lane written
  logic        rd_take;

  // configuration next values
  logic [6:0] next_address;
  logic [5:0] next_v0, next_v1, next_freq, next_lock;
  logic       next_done, next_pg, next_save;
  logic       reg_ok_s1, reg_ok_s2;     // regulation flag synchroniser

  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_byte  = do_write && w_strb[0];
  assign rd_take  = s_axi_arvalid && s_axi_arready;

  // settings: loaded once at apply, then only the bus moves them
  always_comb
  begin
    next_address = device_address;
    next_v0      = channel0_voltage_sel;
    next_v1      = channel1_voltage_sel;
    next_freq    = frequency_sel;
    next_lock    = input_lockout_sel;
    next_done    = config_done;
    next_save    = 1'b0;
    next_pg      = config_done && reg_ok_s2;
    if (phase == APPLY)
    begin
      next_address = scad_addr(sel[scad_pkg::PIN_ADDR]);
      next_v0      = sel[scad_pkg::PIN_V0];
      next_v1      = sel[scad_pkg::PIN_V1];
      next_done    = 1'b1;
      // a saved image overrides the frequency and lockout straps
      if (store_full)
      begin
        next_freq = store_freq;
        next_lock = store_lock;
      end
      else
      begin
        next_freq = sel[scad_pkg::PIN_FREQ];
        next_lock = sel[scad_pkg::PIN_LOCK];
      end
    end
    else if (wr_byte && config_done)
    begin
      // the address register takes no write at all
      unique case (aw_addr)
        scad_pkg::REG_V0:   next_v0   = w_data[5:0];
        scad_pkg::REG_V1:   next_v1   = w_data[5:0];
        scad_pkg::REG_FREQ: next_freq = w_data[5:0];
        scad_pkg::REG_LOCK: next_lock = w_data[5:0];
        scad_pkg::REG_STORE:
        begin
          next_save = w_data[scad_pkg::SC_SAVE];
          if (w_data[scad_pkg::SC_LOAD] && store_full)
          begin
            next_freq = store_freq;
            next_lock = store_lock;
          end
        end
        default: next_save = 1'b0;
      endcase
    end
  end

  // write and read channels
  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    // address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      // the address register is mapped but read-only; writes are dropped
      if (aw_addr <= scad_pkg::REG_STORE && aw_addr[1:0] == 2'h0)
        next_bresp = scad_pkg::RESP_OKAY;
      else
        next_bresp = scad_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // reads answer one cycle after the address is taken
    if (rd_take)
    begin
      next_rvalid = 1'b1;
      next_rresp  = scad_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        scad_pkg::REG_STATUS:
        begin
          next_rdata[scad_pkg::ST_DONE]   = config_done;
          next_rdata[scad_pkg::ST_STORED] = store_full;
          next_rdata[scad_pkg::ST_PG]     = power_good;
          next_rdata[scad_pkg::ST_BAD +: scad_pkg::NUM_PINS] = bad;
        end
        scad_pkg::REG_ADDR:
        begin
          next_rdata[6:0] = device_address;
          next_rdata[scad_pkg::AD_SECOND +: 7] = second_address;
        end
        scad_pkg::REG_V0:    next_rdata[5:0] = channel0_voltage_sel;
        scad_pkg::REG_V1:    next_rdata[5:0] = channel1_voltage_sel;
        scad_pkg::REG_FREQ:  next_rdata[5:0] = frequency_sel;
        scad_pkg::REG_LOCK:  next_rdata[5:0] = input_lockout_sel;
        scad_pkg::REG_STORE: next_rdata[5:0] = 6'h00;
        default:             next_rresp = scad_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_ok_s1            <= 1'b0;
      reg_ok_s2            <= 1'b0;
      device_address       <= scad_pkg::ADDR_OPEN;
      second_address       <= scad_pkg::ADDR_OPEN + 7'h01;
      channel0_voltage_sel <= scad_pkg::SEL_OPEN;
      channel1_voltage_sel <= scad_pkg::SEL_OPEN;
      frequency_sel        <= scad_pkg::SEL_OPEN;
      input_lockout_sel    <= scad_pkg::SEL_OPEN;
      config_done          <= 1'b0;
      power_good           <= 1'b0;
      store_save           <= 1'b0;
      aw_full              <= 1'b0;
      w_full               <= 1'b0;
      aw_addr              <= 8'h00;
      w_data               <= 32'h0000_0000;
      w_strb               <= 4'h0;
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= 2'h0;
      s_axi_arready        <= 1'b0;
      s_axi_rvalid         <= 1'b0;
      s_axi_rresp          <= 2'h0;
      s_axi_rdata          <= 32'h0000_0000;
    end
    else
    begin
      reg_ok_s1            <= outputs_in_regulation;
      reg_ok_s2            <= reg_ok_s1;
      device_address       <= next_address;
      second_address       <= next_address + 7'h01;
      channel0_voltage_sel <= next_v0;
      channel1_voltage_sel <= next_v1;
      frequency_sel        <= next_freq;
      input_lockout_sel    <= next_lock;
      config_done          <= next_done;
      power_good           <= next_pg;
      store_save           <= next_save;
      aw_full              <= next_aw_full;
      w_full               <= next_w_full;
      aw_addr              <= next_aw_addr;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      // ready is the registered inverse of the held flag
      s_axi_awready        <= !next_aw_full;
      s_axi_wready         <= !next_w_full;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      s_axi_arready        <= !next_rvalid;
      s_axi_rvalid         <= next_rvalid;
      s_axi_rresp          <= next_rresp;
      s_axi_rdata          <= next_rdata;
    end
  end

endmodule : scad_top

`default_nettype wire

//--- scad_board.sv
// board straps and resistors on the five multimode pins, as the detector sees them
`timescale 1ns/10ps
`default_nettype none

module scad_board
(
  // wanted connection per pin slot: two kind bits, five step bits
  input  wire logic [9:0]  want_kind,
  input  wire logic [24:0] want_res,
  // detector view of each pin
  output logic      [1:0]  address_select_pin_kind,
  output logic      [4:0]  address_select_pin_res,
  output logic      [1:0]  channel0_voltage_select_pin_kind,
  output logic      [4:0]  channel0_voltage_select_pin_res,
  output logic      [1:0]  channel1_voltage_select_pin_kind,
  output logic      [4:0]  channel1_voltage_select_pin_res,
  output logic      [1:0]  frequency_select_pin_kind,
  output logic      [4:0]  frequency_select_pin_res,
  output logic      [1:0]  input_lockout_select_pin_kind,
  output logic      [4:0]  input_lockout_select_pin_res
);
  logic [24:0] res;  // step lines after the board
  // ========================================
  // a strap gives no resistor reading, so its step lines carry junk
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      res[5*i+:5] = (want_kind[2*i+:2] == 2'h3) ? want_res[5*i+:5]
                                                : ~want_res[5*i+:5];
  end
  // a high strap stands for a tie to internal_low_supply_pin
  assign {input_lockout_select_pin_kind, frequency_select_pin_kind,
          channel1_voltage_select_pin_kind, channel0_voltage_select_pin_kind,
          address_select_pin_kind} = want_kind;
  assign {input_lockout_select_pin_res, frequency_select_pin_res,
          channel1_voltage_select_pin_res, channel0_voltage_select_pin_res,
          address_select_pin_res} = res;
endmodule : scad_board
`default_nettype wire

//--- scad_top_properties.sv
// concurrent checks on the decoded outputs and the bus handshakes
`timescale 1ns/10ps
`default_nettype none

module scad_top_properties
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // decoded configuration
  input wire logic [6:0]  device_address,
  input wire logic [6:0]  second_address,
  input wire logic [5:0]  channel0_voltage_sel,
  input wire logic        config_done,
  input wire logic        power_good,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // one clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ========================================
  // loader outputs
  second_plus_one_a: assert property (config_done |-> second_address == device_address + 7'h01)
    else $error("second address is not the first plus one");
  address_frozen_a: assert property (config_done |=> $stable(device_address))
    else $error("device address moved after apply");
  done_sticky_a: assert property (config_done |=> config_done)
    else $error("config done dropped");
  good_after_done_a: assert property (power_good |-> config_done)
    else $error("power good before configuration");
  address_range_a: assert property (config_done |-> device_address inside {[7'h19:7'h37]})
    else $error("device address out of range");
  voltage_code_a: assert property ($rose(config_done) |-> channel0_voltage_sel <= 6'h21)
    else $error("voltage code beyond last step");

  // ========================================
  // register bus
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  write_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  read_retire_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
endmodule : scad_top_properties

bind scad_top scad_top_properties chk_u (.*);
`default_nettype wire

//--- scad_top_bench.sv
// self-checking bench: boots the loader from straps and reaches its registers
`timescale 1ns/10ps
`default_nettype none

module scad_top_bench;
  // ========================================
  // stimulus and observed signals
  logic        clk_sys = 1'b0, rst_n = 1'b0, outputs_in_regulation = 1'b0;
  logic [9:0]  want_kind = '0;
  logic [24:0] want_res = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;  // always ready for answers
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rdat;
  logic [1:0]  rs;
  wire logic [1:0] address_select_pin_kind, channel0_voltage_select_pin_kind,
    channel1_voltage_select_pin_kind, frequency_select_pin_kind, input_lockout_select_pin_kind;
  wire logic [4:0] address_select_pin_res, channel0_voltage_select_pin_res,
    channel1_voltage_select_pin_res, frequency_select_pin_res, input_lockout_select_pin_res;
  logic [6:0]  device_address, second_address;
  logic [5:0]  channel0_voltage_sel, channel1_voltage_sel, frequency_sel, input_lockout_sel;
  logic        config_done, power_good, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          err_count = 0, checked = 0, cyc = 0;

  always #25 clk_sys = ~clk_sys;  // 20 MHz

  scad_board board_u (.*);

  scad_top dut_u (.*, .s_axi_wstrb(4'hf));

  // ========================================
  // helpers
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // expected selection code: strap kind, then one code per resistor step
  function automatic logic [5:0] sel_of(input logic [1:0] k, input logic [4:0] r);
    if (k != 2'h3)
      return {4'h0, k};
    return (r > 5'd30) ? 6'h01 : 6'h03 + {1'b0, r};
  endfunction : sel_of

  // power-up with given straps, wait for apply; only the hang guard ends a wait
  task automatic boot(input logic [9:0] k, input logic [24:0] r);
    want_kind <= k;
    want_res <= r;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    while (config_done !== 1'b1)
      @(posedge clk_sys);
  endtask : boot

  // bus write: both halves offered, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd

  // hang guard, far above the run's length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  // ========================================
  // main sequence
  initial
  begin
    static logic [1:0] ak[6] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2, 2'h3};  // address pin kinds
    static logic [4:0] ar[6] = '{5'd0, 5'd0, 5'd0, 5'd30, 5'd15, 5'd31};  // last is out of table
    static logic [6:0] ea[6] = '{7'h26, 7'h28, 7'h19, 7'h37, 7'h28, 7'h28};
    logic [1:0] k0, k1, k4;
    outputs_in_regulation <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      k0 = 2'(i % 4);
      k1 = 2'((i + 2) % 4);
      k4 = 2'((i + 1) % 4);
      boot({k4, 2'h3, k1, k0, ak[i]}, {5'(20 + i), 5'(i), 5'(30 - i), 5'(3 * i), ar[i]});
      chk("done", config_done, 1);
      chk("address", device_address, ea[i]);
      chk("second", second_address, ea[i] + 7'h01);
      chk("volt0", channel0_voltage_sel, sel_of(k0, 5'(3 * i)));
      chk("volt1", channel1_voltage_sel, sel_of(k1, 5'(30 - i)));
      chk("freq", frequency_sel, sel_of(2'h3, 5'(i)));
      chk("lock", input_lockout_sel, sel_of(k4, 5'(20 + i)));
    end
    $display("test strap decode done");
    want_kind <= 10'h0;
    repeat (10) @(posedge clk_sys);
    chk("held address", device_address, 7'h28);
    chk("held volt1", channel1_voltage_sel, sel_of(2'h3, 5'd25));
    rd(scad_pkg::REG_STATUS);
    chk("status", {rdat[3], rdat[2], rdat[0]}, 3'b111);
    wr(scad_pkg::REG_ADDR, 32'h55);
    chk("addr write resp", rs, scad_pkg::RESP_OKAY);
    rd(scad_pkg::REG_ADDR);
    chk("addr read", rdat, {17'h0, 7'h29, 1'b0, 7'h28});
    chk("address after write", device_address, 7'h28);
    wr(scad_pkg::REG_V0, 32'h2d);
    rd(scad_pkg::REG_V0);
    chk("volt0 read", rdat, 32'h2d);
    chk("volt0 port", channel0_voltage_sel, 6'h2d);
    wr(8'h1c, 32'h1);
    chk("unmapped", rs, scad_pkg::RESP_SLVERR);
    rd(8'h1c);
    chk("unmapped read", rs, scad_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(scad_pkg::REG_FREQ, 32'h07);
    wr(scad_pkg::REG_LOCK, 32'h09);
    wr(scad_pkg::REG_STORE, 32'h1);
    boot(10'h0, 25'h0);
    chk("stored freq", frequency_sel, 6'h07);
    chk("stored lock", input_lockout_sel, 6'h09);
    chk("pin address", device_address, 7'h26);
    wr(scad_pkg::REG_FREQ, 32'h03);
    wr(scad_pkg::REG_STORE, 32'h2);
    chk("loaded freq", frequency_sel, 6'h07);
    $display("test stored settings done");
    wrap_up();
  end
endmodule : scad_top_bench
`default_nettype wire
